// *** rtl/ssm_code_pkg.sv ***
// Purpose: shared constants and types of the T1 status-message controller
// Assumes: 8-bit registers on a plain strobe port, 12-bit register address
// Notes:   codes travel in 16-bit FDL patterns, first-sent bit at index 0
package ssm_code_pkg;

    // register offsets
    localparam logic [11:0] CODE_CONTROL_ADDR      = 12'h170;
    localparam logic [11:0] RECEIVED_CODE_ADDR     = 12'h171;
    localparam logic [11:0] MATCH_VALUE_ONE_ADDR   = 12'h172;
    localparam logic [11:0] MATCH_VALUE_TWO_ADDR   = 12'h173;
    localparam logic [11:0] MATCH_VALUE_THREE_ADDR = 12'h174;
    localparam logic [11:0] TRANSMIT_CODE_ADDR     = 12'h175;
    localparam logic [11:0] REPEAT_COUNT_ADDR      = 12'h176;
    localparam logic [11:0] INT_STATUS_ADDR        = 12'h177;
    localparam logic [11:0] INT_MASK_ADDR          = 12'h178;
    localparam logic [11:0] LINK_STATUS_ADDR       = 12'h179;

    // reset values and the continuous repeat count
    localparam logic [7:0] REG_RESET          = 8'h00;
    localparam logic [7:0] REPEAT_COUNT_RESET = 8'h01;
    localparam logic [7:0] CONTINUOUS_COUNT   = 8'h00;

    // interrupt status bit positions
    localparam int EV_VALID   = 0;
    localparam int EV_CHANGE  = 1;
    localparam int EV_MATCH1  = 2;
    localparam int EV_MATCH2  = 3;
    localparam int EV_MATCH3  = 4;
    localparam int EV_TX_DONE = 5;
    localparam int EV_WIDTH   = 6;

    // FDL pattern layout: zero, six message bits, zero, eight ones
    localparam int          PAT_LEN     = 16;
    localparam logic [3:0]  PAT_LAST    = 4'hF;
    localparam logic [7:0]  PAT_ONES    = 8'hFF;
    localparam logic [7:0]  IDLE_FLAG   = 8'h7E;
    localparam logic [7:0]  ABORT_OCTET = 8'hFF;
    localparam logic [2:0]  OCTET_LAST  = 3'h7;

    // filter lengths for selector 00, 01, 10, 11
    localparam logic [2:0] FILT_NONE  = 3'h1;
    localparam logic [2:0] FILT_THREE = 3'h3;
    localparam logic [2:0] FILT_FIVE  = 3'h5;
    localparam logic [2:0] FILT_SEVEN = 3'h7;

    typedef struct packed {
        logic       closing_sequence_select;
        logic [1:0] match_filter_sel;
        logic       receive_code_enable;
        logic       code_controller_reset;
        logic [1:0] valid_filter_sel;
        logic       send_code_message;
    } code_ctrl_type;

    typedef struct packed {
        logic       strobe;
        logic       good;
        logic [5:0] msg;
    } pattern_type;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_MSG   = 3'b010,
        TX_CLOSE = 3'b100
    } tx_state_type;

endpackage : ssm_code_pkg

// *** rtl/pattern_filter.sv ***
// Purpose: consecutive error-free pattern qualifier
// Assumes: one pattern report per strobe, same clock as the caller
// Notes:   hit pulses once when a run reaches the selected length
`timescale 1ns/1ps
module pattern_filter
    import ssm_code_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        clear,
    // pattern reports
    input  wire pattern_type pat,
    input  wire logic        same,
    input  wire logic [1:0]  sel,
    // qualified event
    output logic             hit
);
    logic [2:0] run_q;
    logic [2:0] run_d;
    logic [2:0] need;

    // required run length from the selector
    always_comb begin
        case (sel)
            2'b00:   need = FILT_NONE;
            2'b01:   need = FILT_THREE;
            2'b10:   need = FILT_FIVE;
            default: need = FILT_SEVEN;
        endcase
    end

    // a bad pattern breaks the run, a new message starts one
    always_comb begin
        run_d = run_q;
        if (pat.strobe) begin
            if (!pat.good)
                run_d = 3'h0;
            else if (!same)
                run_d = 3'h1;
            else if (run_q != FILT_SEVEN)
                run_d = run_q + 3'h1;
        end
    end

    assign hit = pat.strobe && pat.good && (run_d == need) && (run_q != need);

    // run counter, saturating so the hit cannot repeat within a run
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            run_q <= 3'h0;
        else if (ce) begin
            if (clear)
                run_q <= 3'h0;
            else
                run_q <= run_d;
        end
    end

endmodule : pattern_filter

// *** rtl/t1_ssm_boc_controller.sv ***
// Purpose: T1 status-message code controller, transmit and receive
// Assumes: FDL bit strobes come from framer logic on the same clock
// Notes:   register read data appear the cycle after the read strobe
// Function
// - codes are sent first-bit-rightmost and received in that same order.
// - any six-bit code is carried, covering quality levels 1-7 and user.
// - the receiver looks only at FDL bits for status messages.
// - BOS and MOS indications keep being reported with the receiver on.
// - writing one to the send bit starts a send and the bit self-clears.
// - after a message an idle flag follows, or an abort when selected.
// - the match filter field sets run lengths none, three, five, seven.
// - one match filter serves all three match registers, any message.
// - with the enable bit zero the code receiver is off.
// - the reset bit restores all but interrupt registers and self-clears.
// - the valid filter field gates the valid alarm and received register.
// - the received register holds the last qualified six-bit code.
// - each match register has its own alarm on a qualified match.
// - a change of qualified received message raises an alarm.
// - the transmit register holds the six-bit code that a send inserts.
// - the repeat count sets repetitions, zero meaning continuous.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module t1_ssm_boc_controller
    import ssm_code_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // receive FDL bits
    input  wire logic        rx_fdl_strobe,
    input  wire logic        rx_fdl_bit,
    // transmit FDL bits
    input  wire logic        tx_fdl_req,
    output logic             tx_fdl_bit,
    output logic             tx_active,
    // data link indications
    input  wire logic        bos_detect,
    input  wire logic        mos_detect,
    // interrupt
    output logic             irq
);
    code_ctrl_type        ctrl_q;
    logic                 send_q;
    logic                 soft_rst_q;
    logic [5:0]           received_q;
    logic [5:0]           expect_q [3];
    logic [5:0]           tx_code_q;
    logic [7:0]           repeat_q;
    logic [EV_WIDTH-1:0]  status_q;
    logic [EV_WIDTH-1:0]  mask_q;
    logic [EV_WIDTH-1:0]  events;
    logic [1:0]           link_q;
    logic [15:0]          rx_sr_q;
    logic [15:0]          rx_sr_d;
    logic                 rx_lock_q;
    logic [3:0]           rx_cnt_q;
    logic [5:0]           prev_q;
    logic                 prev_ok_q;
    pattern_type          pat;
    logic                 same;
    logic                 valid_hit;
    logic                 match_hit;
    tx_state_type         tx_state_q;
    logic [15:0]          tx_pat_q;
    logic [3:0]           tx_idx_q;
    logic [7:0]           tx_reps_q;
    logic                 tx_cont_q;
    logic                 tx_bit_q;
    logic                 tx_done;
    logic                 wr_ctrl;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    function automatic logic form_ok(input logic [15:0] p);
        return !p[0] && !p[7] && (p[15:8] == PAT_ONES);
    endfunction : form_ok

    ////////////////////////////////////////////////////////////////////
    // register writes

    assign wr_ctrl = reg_wr && (reg_addr == CODE_CONTROL_ADDR);

    // control word; the two command bits live only as pulses
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            ctrl_q <= code_ctrl_type'(REG_RESET);
        else if (ce) begin
            if (soft_rst_q)
                ctrl_q <= code_ctrl_type'(REG_RESET);
            else if (wr_ctrl) begin
                ctrl_q <= code_ctrl_type'(reg_wdata);
                ctrl_q.code_controller_reset <= 1'b0;
                ctrl_q.send_code_message     <= 1'b0;
            end
        end
    end

    // one-cycle command pulses, self clearing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            send_q     <= 1'b0;
            soft_rst_q <= 1'b0;
        end else if (ce) begin
            send_q     <= wr_ctrl && reg_wdata[0];
            soft_rst_q <= wr_ctrl && reg_wdata[3];
        end
    end

    // match, transmit code and repeat count registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            expect_q  <= '{default: 6'h00};
            tx_code_q <= 6'h00;
            repeat_q  <= REPEAT_COUNT_RESET;
        end else if (ce) begin
            if (soft_rst_q) begin
                expect_q  <= '{default: 6'h00};
                tx_code_q <= 6'h00;
                repeat_q  <= REPEAT_COUNT_RESET;
            end else if (reg_wr) begin
                case (reg_addr)
                    MATCH_VALUE_ONE_ADDR:   expect_q[0] <= reg_wdata[5:0];
                    MATCH_VALUE_TWO_ADDR:   expect_q[1] <= reg_wdata[5:0];
                    MATCH_VALUE_THREE_ADDR: expect_q[2] <= reg_wdata[5:0];
                    TRANSMIT_CODE_ADDR:     tx_code_q <= reg_wdata[5:0];
                    REPEAT_COUNT_ADDR:      repeat_q <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive pattern framing, FDL bits only

    // newest bit enters at the top so the first-sent bit ends at index 0
    assign rx_sr_d = {rx_fdl_bit, rx_sr_q[15:1]};

    always_comb begin
        pat.strobe = 1'b0;
        pat.good   = form_ok(rx_sr_d);
        pat.msg    = rx_sr_d[6:1];
        if (rx_fdl_strobe && ctrl_q.receive_code_enable)
            pat.strobe = rx_lock_q ? (rx_cnt_q == PAT_LAST) : pat.good;
    end

    assign same = prev_ok_q && (pat.msg == prev_q);

    // hunt bit by bit, then check every sixteenth bit once locked
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_sr_q   <= 16'h0000;
            rx_lock_q <= 1'b0;
            rx_cnt_q  <= 4'h0;
        end else if (ce) begin
            if (soft_rst_q || !ctrl_q.receive_code_enable) begin
                rx_lock_q <= 1'b0;
                rx_cnt_q  <= 4'h0;
            end else if (rx_fdl_strobe) begin
                rx_sr_q  <= rx_sr_d;
                rx_cnt_q <= pat.strobe ? 4'h0 : rx_cnt_q + 4'h1;
                if (pat.strobe)
                    rx_lock_q <= pat.good;
            end
        end
    end

    // last strobed message and whether it was well-formed, the reference for a run
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_q    <= 6'h00;
            prev_ok_q <= 1'b0;
        end else if (ce) begin
            if (soft_rst_q)
                prev_ok_q <= 1'b0;
            else if (pat.strobe) begin
                prev_ok_q <= pat.good;
                prev_q    <= pat.msg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // two independent filters

    pattern_filter u_valid_filter (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .clear  (soft_rst_q),
        .pat    (pat),
        .same   (same),
        .sel    (ctrl_q.valid_filter_sel),
        .hit    (valid_hit)
    );

    // shared by all three match registers, any message qualifies
    pattern_filter u_match_filter (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .clear  (soft_rst_q),
        .pat    (pat),
        .same   (same),
        .sel    (ctrl_q.match_filter_sel),
        .hit    (match_hit)
    );

    // received code updates only on a qualified message
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            received_q <= 6'h00;
        else if (ce) begin
            if (soft_rst_q)
                received_q <= 6'h00;
            else if (valid_hit)
                received_q <= pat.msg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // events and interrupt

    always_comb begin
        events             = '0;
        events[EV_VALID]   = valid_hit;
        events[EV_CHANGE]  = valid_hit && (pat.msg != received_q);
        events[EV_MATCH1]  = match_hit && (pat.msg == expect_q[0]);
        events[EV_MATCH2]  = match_hit && (pat.msg == expect_q[1]);
        events[EV_MATCH3]  = match_hit && (pat.msg == expect_q[2]);
        events[EV_TX_DONE] = tx_done;
    end

    // sticky status, write one to clear, a new event wins the clear;
    // kept through the controller reset on purpose
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= '0;
            mask_q   <= '0;
        end else if (ce) begin
            if (reg_wr && reg_addr == INT_STATUS_ADDR)
                status_q <= (status_q & ~reg_wdata[EV_WIDTH-1:0]) | events;
            else
                status_q <= status_q | events;
            if (reg_wr && reg_addr == INT_MASK_ADDR)
                mask_q <= reg_wdata[EV_WIDTH-1:0];
        end
    end

    assign irq = |(status_q & mask_q);

    // link indications pass on regardless of the code receiver
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            link_q <= 2'b00;
        else if (ce)
            link_q <= {mos_detect, bos_detect};
    end

    ////////////////////////////////////////////////////////////////////
    // register reads, one cycle latency, unmapped reads zero

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            reg_rdata <= 8'h00;
        else if (ce) begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    CODE_CONTROL_ADDR:      reg_rdata <= 8'(ctrl_q);
                    RECEIVED_CODE_ADDR:     reg_rdata <= {2'b00, received_q};
                    MATCH_VALUE_ONE_ADDR:   reg_rdata <= {2'b00, expect_q[0]};
                    MATCH_VALUE_TWO_ADDR:   reg_rdata <= {2'b00, expect_q[1]};
                    MATCH_VALUE_THREE_ADDR: reg_rdata <= {2'b00, expect_q[2]};
                    TRANSMIT_CODE_ADDR:     reg_rdata <= {2'b00, tx_code_q};
                    REPEAT_COUNT_ADDR:      reg_rdata <= repeat_q;
                    INT_STATUS_ADDR:        reg_rdata <= {2'b00, status_q};
                    INT_MASK_ADDR:          reg_rdata <= {2'b00, mask_q};
                    LINK_STATUS_ADDR:       reg_rdata <= {4'h0, tx_active,
                                                rx_lock_q, link_q};
                    default:                reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmitter: pattern repeats, closing octet, then idle flags

    assign tx_done = tx_fdl_req && (tx_state_q == TX_CLOSE)
                     && (tx_idx_q[2:0] == OCTET_LAST);

    // a new send restarts even a continuous transmission
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_state_q <= TX_IDLE;
            tx_pat_q   <= 16'h0000;
            tx_idx_q   <= 4'h0;
            tx_reps_q  <= 8'h00;
            tx_cont_q  <= 1'b0;
        end else if (ce) begin
            if (soft_rst_q) begin
                tx_state_q <= TX_IDLE;
                tx_idx_q   <= 4'h0;
            end else if (send_q) begin
                tx_state_q <= TX_MSG;
                tx_pat_q   <= {PAT_ONES, 1'b0, tx_code_q, 1'b0};
                tx_idx_q   <= 4'h0;
                tx_reps_q  <= repeat_q;
                tx_cont_q  <= (repeat_q == CONTINUOUS_COUNT);
            end else if (tx_fdl_req) begin
                tx_idx_q <= tx_idx_q + 4'h1;
                case (tx_state_q)
                    TX_IDLE: tx_idx_q <= {1'b0, tx_idx_q[2:0] + 3'h1};
                    TX_MSG: begin
                        if (tx_idx_q == PAT_LAST && !tx_cont_q) begin
                            tx_reps_q <= tx_reps_q - 8'h01;
                            if (tx_reps_q <= 8'h01)
                                tx_state_q <= TX_CLOSE;
                        end
                    end
                    TX_CLOSE: begin
                        if (tx_idx_q[2:0] == OCTET_LAST) begin
                            tx_state_q <= TX_IDLE;
                            tx_idx_q   <= 4'h0;
                        end
                    end
                    default: tx_state_q <= TX_IDLE;
                endcase
            end
        end
    end

    // line bit, lowest index first, registered on each request
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            tx_bit_q <= 1'b0;
        else if (ce && tx_fdl_req && !send_q && !soft_rst_q) begin
            case (tx_state_q)
                TX_MSG:   tx_bit_q <= tx_pat_q[tx_idx_q];
                TX_CLOSE: tx_bit_q <= ctrl_q.closing_sequence_select
                                      ? ABORT_OCTET[tx_idx_q[2:0]]
                                      : IDLE_FLAG[tx_idx_q[2:0]];
                default:  tx_bit_q <= IDLE_FLAG[tx_idx_q[2:0]];
            endcase
        end
    end

    assign tx_fdl_bit = tx_bit_q;
    assign tx_active  = (tx_state_q != TX_IDLE);

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_send_cmd;
        ce && wr_ctrl && reg_wdata[0] && !reg_wdata[3];
    endsequence

    sequence s_send_started;
        ce && send_q && !soft_rst_q ##1 tx_state_q == TX_MSG;
    endsequence

    a_send_self_clear: assert property (s_send_cmd |=> !ctrl_q.send_code_message
        ##0 s_send_started) else $error("send did not start");

    a_soft_reset_regs: assert property (ce && soft_rst_q |=> received_q == 6'h00
        && expect_q[0] == 6'h00 && repeat_q == REPEAT_COUNT_RESET
        && !ctrl_q.receive_code_enable) else $error("reset incomplete");

    a_rx_off_quiet: assert property (!ctrl_q.receive_code_enable |-> !pat.strobe
        && !valid_hit) else $error("receiver active while off");

    a_received_hold: assert property (ce && !valid_hit && !soft_rst_q
        |=> $stable(received_q)) else $error("received code moved");

    a_valid_update: assert property (ce && valid_hit && !soft_rst_q
        |=> received_q == $past(pat.msg) && status_q[EV_VALID])
        else $error("valid message lost");

    a_change_alarm: assert property (ce && valid_hit && pat.msg != received_q
        |=> status_q[EV_CHANGE]) else $error("change alarm missing");

    a_match_one: assert property (ce && match_hit && pat.msg == expect_q[0]
        |=> status_q[EV_MATCH1]) else $error("match one alarm missing");

    a_abort_close: assert property (ce && tx_fdl_req && tx_state_q == TX_CLOSE
        && ctrl_q.closing_sequence_select && !send_q && !soft_rst_q
        |=> tx_fdl_bit) else $error("abort octet bit not one");

    a_cont_no_close: assert property (tx_cont_q && tx_state_q == TX_MSG
        && !send_q && !soft_rst_q |=> tx_state_q == TX_MSG)
        else $error("continuous send ended");

endmodule : t1_ssm_boc_controller

// *** test/fdl_far_end.sv ***
// Purpose: remote framer model on the facility data link
// Assumes: one FDL bit per strobe, bits go out in pattern order
// Notes:   data line shows the inverse bit between strobes
`timescale 1ns/1ps
module fdl_far_end (
    // clock
    input  wire logic clk,
    // toward the controller
    output logic      rx_fdl_strobe,
    output logic      rx_fdl_bit,
    output logic      tx_fdl_req,
    input  wire logic tx_fdl_bit
);
    logic [15:0] got;

    initial begin
        rx_fdl_strobe = 1'b0;
        rx_fdl_bit    = 1'b0;
        tx_fdl_req    = 1'b0;
        got           = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////
    // zero, code first bit first, zero, eight ones
    task automatic send(input logic [5:0] code, input int n);
        logic [15:0] p;
        p = {8'hFF, 1'b0, code, 1'b0};
        repeat (n) for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            rx_fdl_strobe <= 1'b1;
            rx_fdl_bit    <= p[i];
            @(posedge clk);
            rx_fdl_strobe <= 1'b0;
            rx_fdl_bit    <= ~p[i]; // stale bit must not look valid
        end
    endtask : send

    // bits shift in from the top, first one ends lowest
    task automatic take(input int n);
        repeat (n) begin
            @(posedge clk);
            tx_fdl_req <= 1'b1;
            @(posedge clk);
            tx_fdl_req <= 1'b0;
            @(posedge clk);
            got = {tx_fdl_bit, got[15:1]};
        end
    endtask : take
endmodule : fdl_far_end

// *** test/t1_ssm_boc_controller_bench.sv ***
// Purpose: self-checking bench of the status-message code controller
// Assumes: far-end model drives FDL strobes; ce held high
// Notes:   both filters are walked through every selector value
`timescale 1ns/1ps
module t1_ssm_boc_controller_bench
    import ssm_code_pkg::*;
;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        rx_fdl_strobe, rx_fdl_bit, tx_fdl_req, tx_fdl_bit;
    logic        tx_active, irq;
    logic        bos_detect = 1'b1;
    logic        mos_detect = 1'b0;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    always #25 clk = ~clk;

    t1_ssm_boc_controller i_dut (.clk(clk), .resetn(resetn), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_fdl_strobe(rx_fdl_strobe), .rx_fdl_bit(rx_fdl_bit),
        .tx_fdl_req(tx_fdl_req), .tx_fdl_bit(tx_fdl_bit),
        .tx_active(tx_active), .bos_detect(bos_detect),
        .mos_detect(mos_detect), .irq(irq));
    fdl_far_end i_far (.clk(clk), .rx_fdl_strobe(rx_fdl_strobe),
        .rx_fdl_bit(rx_fdl_bit), .tx_fdl_req(tx_fdl_req),
        .tx_fdl_bit(tx_fdl_bit));

    ////////////////////////////////////////////////////////////////////
    // shared bus cycles and comparison
    task automatic chk(input string w, input logic [15:0] s, e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rchk(input string w, input logic [11:0] a,
                        input logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(w, {8'h00, reg_rdata}, {8'h00, e});
    endtask : rchk

    ////////////////////////////////////////////////////////////////////
    task automatic test_reset_values();
        for (int i = 0; i < 7; i++)
            rchk("reset", CODE_CONTROL_ADDR + 12'(i),
                 (i == 6) ? REPEAT_COUNT_RESET : REG_RESET);
        wr(12'h17A, 8'hFF);
        rchk("unmapped", 12'h17A, 8'h00);
        wr(RECEIVED_CODE_ADDR, 8'h3F);
        rchk("read only", RECEIVED_CODE_ADDR, 8'h00);
    endtask : test_reset_values

    // one repeat with idle flag, then two repeats closed by abort
    task automatic test_transmit();
        wr(TRANSMIT_CODE_ADDR, 8'h18);
        wr(CODE_CONTROL_ADDR, 8'h01);
        rchk("send clear", CODE_CONTROL_ADDR, 8'h00);
        i_far.take(16);
        chk("pattern", i_far.got, {8'hFF, 8'h30});
        i_far.take(8);
        chk("idle", i_far.got[15:8], IDLE_FLAG);
        rchk("tx done", INT_STATUS_ADDR, 8'h20);
        wr(INT_STATUS_ADDR, 8'hFF);
        wr(REPEAT_COUNT_ADDR, 8'h02);
        wr(CODE_CONTROL_ADDR, 8'h81);
        for (int r = 0; r < 2; r++) begin
            i_far.take(16);
            chk("repeat", i_far.got, {8'hFF, 8'h30});
        end
        i_far.take(8);
        chk("abort", i_far.got[15:8], ABORT_OCTET);
        // count zero keeps sending until a definite count is resent
        wr(REPEAT_COUNT_ADDR, CONTINUOUS_COUNT);
        wr(CODE_CONTROL_ADDR, 8'h01);
        for (int r = 0; r < 3; r++) begin
            i_far.take(16);
            chk("continuous", i_far.got, {8'hFF, 8'h30});
        end
        chk("still on", {15'h0000, tx_active}, 16'h0001);
        wr(REPEAT_COUNT_ADDR, REPEAT_COUNT_RESET);
        wr(CODE_CONTROL_ADDR, 8'h01);
        i_far.take(24);
        chk("stopped", i_far.got, {IDLE_FLAG, 8'hFF});
        wr(INT_STATUS_ADDR, 8'hFF);
    endtask : test_transmit

    task automatic test_disabled();
        wr(CODE_CONTROL_ADDR, 8'h00);
        i_far.send(6'h18, 3);
        rchk("rx off", RECEIVED_CODE_ADDR, 8'h00);
        rchk("no event", INT_STATUS_ADDR, 8'h00);
    endtask : test_disabled

    // each selector: one pattern short, then the qualifying one
    task automatic test_filters();
        for (int s = 0; s < 4; s++) begin
            wr(CODE_CONTROL_ADDR, 8'h08);
            wr(INT_STATUS_ADDR, 8'hFF);
            wr(MATCH_VALUE_ONE_ADDR, 8'h18);
            wr(MATCH_VALUE_TWO_ADDR, 8'h19);
            wr(MATCH_VALUE_THREE_ADDR, 8'h18);
            wr(CODE_CONTROL_ADDR, {1'b0, 2'(s), 2'b10, 2'(s), 1'b0});
            i_far.send(6'h18, 2 * s);
            rchk("short run", INT_STATUS_ADDR, 8'h00);
            i_far.send(6'h18, 1);
            rchk("code", RECEIVED_CODE_ADDR, 8'h18);
            rchk("events", INT_STATUS_ADDR, 8'h17);
        end
        // a new code restarts both runs; only match two agrees with it
        wr(INT_STATUS_ADDR, 8'hFF);
        i_far.send(6'h19, 7);
        rchk("new code", RECEIVED_CODE_ADDR, 8'h19);
        rchk("new events", INT_STATUS_ADDR, 8'h0B);
        rchk("link", LINK_STATUS_ADDR, 8'h05);
    endtask : test_filters

    // irq follows masked status; soft reset spares interrupt registers
    task automatic test_irq_reset();
        chk("irq off", {15'h0000, irq}, 16'h0000);
        wr(INT_MASK_ADDR, 8'h08);
        repeat (2) @(negedge clk);
        chk("irq on", {15'h0000, irq}, 16'h0001);
        wr(INT_STATUS_ADDR, 8'h08);
        repeat (2) @(negedge clk);
        chk("irq clear", {15'h0000, irq}, 16'h0000);
        wr(CODE_CONTROL_ADDR, 8'h08);
        rchk("kept", INT_STATUS_ADDR, 8'h03);
        rchk("rx default", RECEIVED_CODE_ADDR, 8'h00);
        rchk("match default", MATCH_VALUE_ONE_ADDR, 8'h00);
        rchk("ctrl default", CODE_CONTROL_ADDR, 8'h00);
    endtask : test_irq_reset

    task automatic print_verdict();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        test_reset_values();
        test_transmit();
        test_disabled();
        test_filters();
        test_irq_reset();
        print_verdict();
    end

    // hang guard, far beyond the roughly 1500 cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule : t1_ssm_boc_controller_bench
